// *** rtl/dcc_top.sv ***
// dual comparator control: registers, event flag, pin routing
`timescale 1ns/100ps

// Function
// - three-bit mode field selects eight modes
// - raw output high when plus exceeds minus
// - internal reference only in mode 110
// - result bits 7:6 read-only
// - routed pins carry unsynchronized results
// - direction bits still enable routed pins
// - bits 5:4 invert each result
// - analog pins read as zero in every mode but 111
// - any result change sets the flag
// - flag written zero clears, one sets
// - request needs all three enables set
// - change during read still sets the flag
// - control access captures results, ending the mismatch
// - active comparator wakes from sleep
// - mode 111 powers both comparators off
// - wake leaves control register unchanged
// - reset forces mode 000, comparators off
// - switch bit picks minus pair in 110
// - result equals raw XOR invert bit
module dcc_top
  import dcc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator cells
  input  wire logic [1:0]  cmp_raw_async,
  output dcc_ana_s         ana_ctrl,
  // port f pins
  input  wire logic [7:0]  port_f_in,
  output logic      [7:0]  port_f_out,
  output logic      [7:0]  port_f_oe,
  // system
  input  wire logic        sleep_mode,
  output logic             irq_req,
  output logic             wake_req
);

  // ********************************
  // state and wiring
  // ********************************
  dcc_ctrl_s   ctrl_r;
  logic        flag_r;
  logic        cie_r;
  logic [1:0]  core_en_r;
  logic [7:0]  dir_r;
  logic [7:0]  latch_r;
  logic [31:0] prdata_r;
  logic [1:0]  seen_r;
  dcc_ana_s    ana_r;

  logic [1:0]  raw_sync;
  logic [7:0]  pin_sync;
  logic [1:0]  inv;
  logic [1:0]  result;
  logic [1:0]  result_async;
  logic        mismatch;
  logic [7:0]  analog_mask;
  logic        route_en;
  logic        setup;
  logic        access;
  logic        hit;
  logic        wr;
  logic [7:0]  rdata;
  logic        sel_ctrl;

  // every check below runs on pclk and sleeps through reset
  default clocking dcc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ********************************
  // apb decode
  // ********************************
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign sel_ctrl = (paddr == DCC_OFF_CTRL);
  assign wr       = access & pwrite & hit;

  // known word offsets only; others answer with error
  always_comb begin
    case (paddr)
      DCC_OFF_CTRL,
      DCC_OFF_FLAGS,
      DCC_OFF_ENAB,
      DCC_OFF_CORE,
      DCC_OFF_DIR,
      DCC_OFF_PORT,
      DCC_OFF_LATCH: hit = 1'b1;
      default:       hit = 1'b0;
    endcase
  end

  // zero wait: answer in the first access cycle
  assign pready  = access;
  assign pslverr = access & ~hit;

  // ********************************
  // comparator results
  // ********************************
  // raw high means plus input above minus input
  assign inv = {ctrl_r.second_result_invert,
                ctrl_r.first_result_invert};

  dcc_sync #(
    .W (2)
  ) u_raw_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cmp_raw_async),
    .sync_out (raw_sync)
  );

  // clean copy for flag and reads; avoids a metastable flag
  assign result       = raw_sync ^ inv;
  assign result_async = cmp_raw_async ^ inv;

  // ********************************
  // control register
  // ********************************
  // result bits are not stored; they read live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= dcc_ctrl_s'(DCC_CTRL_RST);
    end else if (wr && sel_ctrl) begin
      ctrl_r <= dcc_ctrl_s'(pwdata[7:0] & DCC_WMASK_CTRL);
    end
  end

  // last value software saw; any control access refreshes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 2'h0;
    end else if (access && sel_ctrl) begin
      seen_r <= result;
    end
  end

  // a change that lands on the read edge still raises mismatch
  assign mismatch = (result != seen_r);

  // ********************************
  // event flag and enables
  // ********************************
  // mismatch wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (mismatch) begin
      flag_r <= 1'b1;
    end else if (wr && paddr == DCC_OFF_FLAGS) begin
      flag_r <= pwdata[DCC_FLAG_BIT];
    end
  end

  // comparator enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cie_r <= 1'b0;
    end else if (wr && paddr == DCC_OFF_ENAB) begin
      cie_r <= pwdata[DCC_ENAB_BIT];
    end
  end

  // global and peripheral enables, {global, peripheral}
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_en_r <= 2'h0;
    end else if (wr && paddr == DCC_OFF_CORE) begin
      core_en_r <= {pwdata[DCC_GLOBAL_EN_BIT], pwdata[DCC_PERIPH_EN_BIT]};
    end
  end

  // the flag sets whatever the enables say
  assign irq_req = flag_r & cie_r & (&core_en_r);

  // sleep touches no register, only asks for wake
  assign wake_req = sleep_mode & flag_r & cie_r;

  // ********************************
  // port f registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= DCC_DIR_RST;
    end else if (wr && paddr == DCC_OFF_DIR) begin
      dir_r <= pwdata[7:0];
    end
  end

  // writes to the port data word also land here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= DCC_LATCH_RST;
    end else if (wr && (paddr == DCC_OFF_LATCH ||
                        paddr == DCC_OFF_PORT)) begin
      latch_r <= pwdata[7:0];
    end
  end

  dcc_sync #(
    .W (8)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (port_f_in),
    .sync_out (pin_sync)
  );

  // ********************************
  // mode decode and pin routing
  // ********************************
  // every mode but off keeps the analog inputs claimed
  assign analog_mask =
    (ctrl_r.comparator_mode_select == DCC_MODE_OFF) ?
    8'h00 : DCC_ANALOG_MASK;

  assign route_en =
    (ctrl_r.comparator_mode_select == DCC_MODE_3) ||
    (ctrl_r.comparator_mode_select == DCC_MODE_5);

  dcc_pin_mux u_pin_mux (
    .route_en     (route_en),
    .result_async (result_async),
    .analog_mask  (analog_mask),
    .latch        (latch_r),
    .direction    (dir_r),
    .pin_out      (port_f_out),
    .pin_oe       (port_f_oe)
  );

  // analog steering; reset holds cells powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_r <= dcc_ana_s'({2'h0, 1'b0, 1'b0, DCC_MODE_RESET});
    end else begin
      ana_r.mode <= ctrl_r.comparator_mode_select;
      ana_r.power_en <=
        (ctrl_r.comparator_mode_select == DCC_MODE_OFF ||
         ctrl_r.comparator_mode_select == DCC_MODE_RESET) ?
        2'h0 : 2'h3;
      ana_r.ref_to_positive <=
        (ctrl_r.comparator_mode_select == DCC_MODE_MUX4);
      ana_r.pair_switch <= ctrl_r.input_pair_switch &&
        (ctrl_r.comparator_mode_select == DCC_MODE_MUX4);
    end
  end

  assign ana_ctrl = ana_r;

  // ********************************
  // read path
  // ********************************
  always_comb begin
    case (paddr)
      DCC_OFF_CTRL:  rdata = {result[1], result[0],
                              ctrl_r[5:0]};
      DCC_OFF_FLAGS: rdata = 8'(flag_r) << DCC_FLAG_BIT;
      DCC_OFF_ENAB:  rdata = 8'(cie_r) << DCC_ENAB_BIT;
      DCC_OFF_CORE:  rdata = 8'(core_en_r) << DCC_PERIPH_EN_BIT;
      DCC_OFF_DIR:   rdata = dir_r;
      DCC_OFF_PORT:  rdata = pin_sync & ~analog_mask;
      DCC_OFF_LATCH: rdata = latch_r;
      default:       rdata = 8'h00;
    endcase
  end

  // read data sampled in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rdata};
    end
  end

  assign prdata = prdata_r;

  // ********************************
  // checks
  // ********************************
  mode_write_a: assert property (
    wr && sel_ctrl |=> ctrl_r.comparator_mode_select == $past(pwdata[2:0]))
    else $error("mode field did not take the written value");

  ro_bits_a: assert property (
    setup && sel_ctrl |=> prdata[7:6] == $past(result))
    else $error("result bits read wrong");

  flag_set_a: assert property (
    mismatch |=> flag_r)
    else $error("flag missed a result change");

  flag_hold_a: assert property (
    mismatch && wr && paddr == DCC_OFF_FLAGS |=> flag_r)
    else $error("clear won over a live mismatch");

  capture_a: assert property (
    access && sel_ctrl ##1 $stable(result) |-> !mismatch)
    else $error("control access did not end mismatch");

  irq_gate_a: assert property (
    !core_en_r[1] || !core_en_r[0] || !cie_r |-> !irq_req)
    else $error("request raised with an enable clear");

  analog_zero_a: assert property (
    setup && paddr == DCC_OFF_PORT && analog_mask != 8'h00
    |=> (prdata[7:0] & DCC_ANALOG_MASK) == 8'h00)
    else $error("analog pin read nonzero");

  pin_route_a: assert property (
    route_en && !dir_r[DCC_PIN_FIRST]
    |-> port_f_oe[DCC_PIN_FIRST] &&
        port_f_out[DCC_PIN_FIRST] == result_async[0])
    else $error("routed pin not driven by result");

  off_power_a: assert property (
    ctrl_r.comparator_mode_select == DCC_MODE_OFF
    |=> ana_ctrl.power_en == 2'h0)
    else $error("comparators powered in off mode");

  pair_sel_a: assert property (
    ana_ctrl.pair_switch |-> ana_ctrl.ref_to_positive)
    else $error("pair switch outside four input mode");

  invert_a: assert property (
    $changed(inv[0]) && $stable(raw_sync[0])
    |-> result[0] != $past(result[0]))
    else $error("invert bit did not flip result");

  wake_a: assert property (
    sleep_mode && flag_r && cie_r |-> wake_req)
    else $error("enabled event did not wake");

endmodule // dcc_top

// *** rtl/dcc_pkg.sv ***
// constants and types for the dual comparator control block
package dcc_pkg;

  // ********************************
  // register map, byte addresses
  // ********************************
  localparam logic [7:0] DCC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] DCC_OFF_FLAGS = 8'h04;
  localparam logic [7:0] DCC_OFF_ENAB  = 8'h08;
  localparam logic [7:0] DCC_OFF_CORE  = 8'h0C;
  localparam logic [7:0] DCC_OFF_DIR   = 8'h10;
  localparam logic [7:0] DCC_OFF_PORT  = 8'h14;
  localparam logic [7:0] DCC_OFF_LATCH = 8'h18;

  // ********************************
  // field positions and reset values
  // ********************************
  localparam int DCC_FLAG_BIT = 6;
  localparam int DCC_ENAB_BIT = 6;
  localparam int DCC_PERIPH_EN_BIT = 6;
  localparam int DCC_GLOBAL_EN_BIT = 7;
  localparam int DCC_PIN_FIRST  = 2;
  localparam int DCC_PIN_SECOND = 1;
  localparam logic [7:0] DCC_CTRL_RST  = 8'h00;
  localparam logic [7:0] DCC_DIR_RST   = 8'hFF;
  localparam logic [7:0] DCC_LATCH_RST = 8'h00;
  localparam logic [7:0] DCC_ANALOG_MASK = 8'h78;
  localparam logic [7:0] DCC_WMASK_CTRL  = 8'h3F;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {
    DCC_MODE_RESET = 3'b000,
    DCC_MODE_1     = 3'b001,
    DCC_MODE_2     = 3'b010,
    DCC_MODE_3     = 3'b011,
    DCC_MODE_4     = 3'b100,
    DCC_MODE_5     = 3'b101,
    DCC_MODE_MUX4  = 3'b110,
    DCC_MODE_OFF   = 3'b111
  } dcc_mode_e;

  typedef struct packed {
    logic      second_compare_result;
    logic      first_compare_result;
    logic      second_result_invert;
    logic      first_result_invert;
    logic      input_pair_switch;
    dcc_mode_e comparator_mode_select;
  } dcc_ctrl_s;

  // steering towards the analog comparator cells
  typedef struct packed {
    logic [1:0] power_en;
    logic       ref_to_positive;
    logic       pair_switch;
    dcc_mode_e  mode;
  } dcc_ana_s;

endpackage

// *** rtl/dcc_sync.sv ***
// three stage synchroniser with agreement filter
`timescale 1ns/100ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // asynchronous in, clean out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r;

  // chain; first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_r <= '0;
    end else begin
      stable_r <= (s2_r & ~(s2_r ^ s3_r)) | (stable_r & (s2_r ^ s3_r));
    end
  end

  assign sync_out = stable_r;

endmodule // dcc_sync

// *** rtl/dcc_pin_mux.sv ***
// port pin output multiplexer for comparator results
`timescale 1ns/100ps
module dcc_pin_mux
  import dcc_pkg::*;
(
  // steering
  input  wire logic       route_en,
  input  wire logic [1:0] result_async,
  input  wire logic [7:0] analog_mask,
  // port registers
  input  wire logic [7:0] latch,
  input  wire logic [7:0] direction,
  // pins
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe
);

  // results bypass the latch with no sync: pins follow the cell
  always_comb begin
    pin_out = latch;
    if (route_en) begin
      pin_out[DCC_PIN_FIRST]  = result_async[0];
      pin_out[DCC_PIN_SECOND] = result_async[1];
    end
  end

  // direction bit 1 means input; it still gates routed pins
  assign pin_oe = ~direction & ~analog_mask;

endmodule // dcc_pin_mux

// *** verification/dcc_cells_model.sv ***
// behavioural comparator cells and port f pads facing the block
`timescale 1ns/100ps
module dcc_cells_model
  import dcc_pkg::*;
(
  // steering from the block
  input  wire dcc_ana_s   ana_ctrl,
  // bench commands: 1 = plus above minus, outside pin levels
  input  wire logic [1:0] level_cmd,
  input  wire logic [7:0] ext_pins,
  // pad drive from the block
  input  wire logic [7:0] port_f_out,
  input  wire logic [7:0] port_f_oe,
  // towards the block
  output logic      [1:0] cmp_raw_async,
  output logic      [7:0] port_f_in
);
  // an unpowered cell idles low, so mode 000 and 111 give no result
  assign cmp_raw_async =
    level_cmd & ana_ctrl.power_en;
  // pads driven by the block win over the outside level
  assign port_f_in =
    (port_f_oe & port_f_out) | (~port_f_oe & ext_pins);
endmodule // dcc_cells_model

// *** verification/dcc_top_tb.sv ***
// self-checking bench for the dual comparator control block
`timescale 1ns/100ps
module dcc_top_tb;
  import dcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, port_f_in, port_f_out, port_f_oe, ext_pins;
  logic [31:0] pwdata, prdata;
  logic [1:0]  cmp_raw_async, level_cmd;
  logic        sleep_mode, irq_req, wake_req;
  dcc_ana_s    ana_ctrl;
  int          err_total = 0;
  int          comparisons = 0;

  dcc_top u_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_raw_async(cmp_raw_async), .ana_ctrl(ana_ctrl),
    .port_f_in(port_f_in), .port_f_out(port_f_out), .port_f_oe(port_f_oe),
    .sleep_mode(sleep_mode), .irq_req(irq_req), .wake_req(wake_req));
  dcc_cells_model u_dcc_cells_model (.ana_ctrl(ana_ctrl),
    .level_cmd(level_cmd), .ext_pins(ext_pins), .port_f_out(port_f_out),
    .port_f_oe(port_f_oe), .cmp_raw_async(cmp_raw_async),
    .port_f_in(port_f_in));

  // ****************
  // helpers
  // ****************
  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high,
  // a hung slave is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
    logic [7:0] r;
    logic       e;
    apb(1'b0, a, 8'h00, r, e);
    chk(what, r, exp);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rchk(DCC_OFF_CTRL, 8'h00, "ctrl rst");
    rchk(DCC_OFF_DIR, 8'hFF, "dir rst");
    rchk(DCC_OFF_FLAGS, 8'h00, "flag rst");
    $display("test reset done");
  endtask
  // every mode code, power and reference steering
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(DCC_OFF_CTRL, 8'(m));
      repeat (2) @(posedge pclk);
      chk("mode", 8'(ana_ctrl.mode), 8'(m));
      chk("power", 8'(ana_ctrl.power_en),
          (m % 7 == 0) ? 8'h00 : 8'h03);
      chk("ref", 8'(ana_ctrl.ref_to_positive), 8'(m == 6));
    end
    wr(DCC_OFF_CTRL, 8'h0E);
    repeat (2) @(posedge pclk);
    chk("pair set", 8'(ana_ctrl.pair_switch), 8'h01);
    wr(DCC_OFF_CTRL, 8'h06);
    repeat (2) @(posedge pclk);
    chk("pair clr", 8'(ana_ctrl.pair_switch), 8'h00);
    wr(DCC_OFF_CTRL, 8'hC7);
    repeat (6) @(posedge pclk);
    rchk(DCC_OFF_CTRL, 8'h07, "result ro");
    $display("test modes done");
  endtask
  task automatic t_results;
    wr(DCC_OFF_CTRL, 8'h01);
    level_cmd <= 2'b01;
    repeat (8) @(posedge pclk);
    rchk(DCC_OFF_CTRL, 8'h41, "raw result");
    wr(DCC_OFF_CTRL, 8'h31);
    repeat (3) @(posedge pclk);
    rchk(DCC_OFF_CTRL, 8'hB1, "inverted");
    $display("test results done");
  endtask
  // flag: set on change, held by mismatch, written both ways
  task automatic t_flag;
    wr(DCC_OFF_FLAGS, 8'h00);
    rchk(DCC_OFF_FLAGS, 8'h00, "flag clr");
    level_cmd <= 2'b11;
    repeat (8) @(posedge pclk);
    rchk(DCC_OFF_FLAGS, 8'h40, "flag change");
    wr(DCC_OFF_FLAGS, 8'h00);
    rchk(DCC_OFF_FLAGS, 8'h40, "flag held");
    rchk(DCC_OFF_CTRL, 8'h31, "ctrl capture");
    wr(DCC_OFF_FLAGS, 8'h00);
    rchk(DCC_OFF_FLAGS, 8'h00, "flag freed");
    wr(DCC_OFF_FLAGS, 8'h40);
    rchk(DCC_OFF_FLAGS, 8'h40, "flag soft");
    $display("test flag done");
  endtask
  task automatic t_irq;
    for (int k = 0; k < 8; k++) begin
      wr(DCC_OFF_ENAB, {1'b0, k[0], 6'h00});
      wr(DCC_OFF_CORE, {k[2:1], 6'h00});
      @(posedge pclk);
      chk("irq", 8'(irq_req), 8'(k == 7));
    end
    rchk(DCC_OFF_FLAGS, 8'h40, "flag kept");
    sleep_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("wake", 8'(wake_req), 8'h01);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("wake off", 8'(wake_req), 8'h00);
    rchk(DCC_OFF_CTRL, 8'h31, "ctrl kept");
    $display("test irq done");
  endtask
  // routed pins follow the raw result at once, gated by direction
  // the mode change runs with the comparator enable masked
  task automatic t_pins;
    wr(DCC_OFF_ENAB, 8'h00);
    wr(DCC_OFF_CTRL, 8'h03);
    wr(DCC_OFF_DIR, 8'hF9);
    level_cmd <= 2'b01;
    repeat (2) @(posedge pclk);
    chk("pin oe", port_f_oe & 8'h06, 8'h06);
    chk("irq masked", 8'(irq_req), 8'h00);
    level_cmd <= 2'b10;
    #1;
    chk("pin out", port_f_out & 8'h06, 8'h02);
    wr(DCC_OFF_DIR, 8'h00);
    repeat (2) @(posedge pclk);
    chk("analog oe", port_f_oe, 8'h87);
    wr(DCC_OFF_DIR, 8'hFF);
    repeat (6) @(posedge pclk);
    chk("pin off", port_f_oe, 8'h00);
    rchk(DCC_OFF_PORT, 8'h87, "port read");
    $display("test pins done");
  endtask
  task automatic t_unmapped;
    logic [7:0] r;
    logic       e;
    apb(1'b0, 8'h1C, 8'h00, r, e);
    chk("slverr", {7'h00, e}, 8'h01);
    chk("hole data", r, 8'h00);
    $display("test unmapped done");
  endtask
  // reset in mid-run must undo earlier writes
  task automatic t_rst_mid;
    wr(DCC_OFF_DIR, 8'h00);
    wr(DCC_OFF_ENAB, 8'h40);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("ana mid", {1'b0, ana_ctrl}, 8'h00);
    chk("oe mid", port_f_oe, 8'h00);
    chk("irq mid", 8'(irq_req), 8'h00);
    presetn <= 1'b1;
    rchk(DCC_OFF_CTRL, 8'h00, "ctrl mid");
    rchk(DCC_OFF_ENAB, 8'h00, "enab mid");
    rchk(DCC_OFF_DIR, 8'hFF, "dir mid");
    rchk(DCC_OFF_FLAGS, 8'h00, "flag mid");
    $display("test mid reset done");
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    {psel, penable, pwrite, sleep_mode, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    level_cmd = 2'b00;
    ext_pins = 8'hFF;
    repeat (5) @(posedge pclk);
    chk("ana rst", {1'b0, ana_ctrl}, 8'h00);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_results;
    t_flag;
    t_irq;
    t_pins;
    t_unmapped;
    t_rst_mid;
    give_verdict;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("timeout");
    give_verdict;
  end
endmodule // dcc_top_tb
